// ==== ddc_command_parser.sv ====
// Command interpreter: syntax check, letter buffer, ordered execution, poll byte.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ddc_command_parser
    import ddc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic        atn,
    input  wire logic        remote,
    input  wire logic        dev_clear,
    input  wire logic        loop_init,
    input  wire logic        matrix_ready,
    input  wire logic        spoll_req,
    output logic [7:0]       spoll_byte,
    output logic             spoll_ack,
    output logic             srq,
    output logic             slave_clear,
    output logic             exec_valid,
    output logic [4:0]       exec_cmd,
    output logic [18:0]      exec_value,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             irq
);
    typedef enum logic [4:0] {
        ST_CMD  = 5'b00001,
        ST_OPT  = 5'b00010,
        ST_DROP = 5'b00100,
        ST_RD   = 5'b01000,
        ST_OUT  = 5'b10000
    } state_t;

    logic rst_sync_n;
    ddc_reset_sync u_rst (.mclk(mclk), .rst_n(rst_n), .rst_sync_n(rst_sync_n));

    state_t        st_q, st_d;
    logic [4:0]    cur_q, cur_d;
    logic [15:0]   val_q, val_d;
    logic [2:0]    row_q, row_d;
    logic          dig_q, dig_d, rowseen_q, rowseen_d;
    logic [25:0]   pend_q, pend_d;
    logic [4:0]    idx_q, idx_d;
    logic          we;
    logic [18:0]   rdata;
    logic          ev_bad_cmd, ev_bad_opt, ev_not_rem;
    logic [4:0]    lt;
    logic [3:0]    digit;
    logic          is_dig, is_let, rowcmd, multi, grp_ok, take;

    assign take     = rx_valid && rx_ready && !atn;
    assign rx_ready = st_q[0] || st_q[1] || st_q[2];
    assign lt       = 5'(rx_data - CH_A);
    assign digit    = 4'(rx_data - CH_ZERO);
    assign is_dig   = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);
    assign is_let   = (rx_data >= CH_A) && (rx_data <= CH_Z);
    assign rowcmd   = (cur_q == L_C) || (cur_q == L_N);
    assign multi    = rowcmd || (cur_q == L_D) || (cur_q == L_Z);
    // A group is complete when it has its digits, a row if it is a C or N group, and a legal value.
    assign grp_ok   = dig_q && (val_q <= opt_max(cur_q)) && (!rowcmd || rowseen_q)
                      && (!rowcmd || val_q <= COL_MAX);

    ddc_cmd_store u_store (.mclk(mclk), .we(we), .waddr(cur_q),
        .wdata({row_q, val_q}), .raddr(PRIO[idx_q]), .rdata(rdata));

    always_comb
    begin
        st_d = st_q; cur_d = cur_q; val_d = val_q; row_d = row_q; dig_d = dig_q;
        rowseen_d = rowseen_q; pend_d = pend_q; idx_d = idx_q; we = 1'b0;
        ev_bad_cmd = 1'b0; ev_bad_opt = 1'b0; ev_not_rem = 1'b0;
        unique case (st_q)
            ST_CMD, ST_OPT:
                if (take && rx_data != CH_SPACE)
                begin
                    if (st_q == ST_OPT && is_dig)
                    begin
                        val_d = (val_q > 16'h1998) ? VAL_MAX : 16'(val_q * 16'h000A + digit);
                        dig_d = 1'b1;
                    end
                    else if (st_q == ST_OPT && rx_data == CH_COMMA)
                    begin
                        if (multi && grp_ok)
                        begin
                            we = 1'b1; val_d = '0; dig_d = 1'b0; rowseen_d = 1'b0;
                        end
                        else
                        begin
                            ev_bad_opt = 1'b1; st_d = ST_DROP;
                        end
                    end
                    else if (st_q == ST_OPT && rowcmd && is_let && rx_data <= CH_H
                             && !(dig_q && rowseen_q))
                    begin
                        if (rowseen_q)
                        begin
                            ev_bad_opt = 1'b1; st_d = ST_DROP;
                        end
                        else
                        begin
                            row_d = lt[2:0]; rowseen_d = 1'b1;
                        end
                    end
                    else if (st_q == ST_OPT && rowcmd && is_let && rx_data <= CH_H)
                    begin
                        ev_bad_opt = 1'b1; st_d = ST_DROP;
                    end
                    else if (st_q == ST_OPT && !grp_ok)
                    begin
                        ev_bad_opt = 1'b1; st_d = ST_DROP;
                        if (rx_data == CH_X)
                        begin
                            st_d = ST_CMD; pend_d = '0;
                        end
                    end
                    else
                    begin
                        if (st_q == ST_OPT)
                        begin
                            we = 1'b1;
                            pend_d[cur_q] = 1'b1;
                        end
                        val_d = '0; dig_d = 1'b0; rowseen_d = 1'b0; row_d = '0;
                        if (rx_data == CH_X)
                        begin
                            idx_d = '0;
                            if (!remote)
                            begin
                                ev_not_rem = 1'b1; st_d = ST_CMD; pend_d = '0;
                            end
                            else
                                st_d = ST_RD;
                        end
                        else if (is_let && is_cmd(lt))
                        begin
                            cur_d = lt; st_d = ST_OPT;
                        end
                        else
                        begin
                            ev_bad_cmd = 1'b1; st_d = ST_DROP;
                        end
                    end
                end
            ST_DROP:
                if (take && rx_data == CH_X)
                begin
                    st_d = ST_CMD; pend_d = '0;
                end
            ST_RD:
                if (pend_q[PRIO[idx_q]])
                    st_d = ST_OUT;
                else if (idx_q == PRIO_LAST)
                    st_d = ST_CMD;
                else
                    idx_d = 5'(idx_q + 5'h01);
            ST_OUT:
            begin
                pend_d[PRIO[idx_q]] = 1'b0;
                st_d = (idx_q == PRIO_LAST) ? ST_CMD : ST_RD;
                // Stopping at the last index keeps the order table read in range.
                idx_d = (idx_q == PRIO_LAST) ? idx_q : 5'(idx_q + 5'h01);
            end
            default: st_d = ST_CMD;
        endcase
        if (dev_clear)
        begin
            st_d = ST_CMD; pend_d = '0; idx_d = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_q <= ST_CMD; cur_q <= '0; val_q <= '0; row_q <= '0; dig_q <= 1'b0;
            rowseen_q <= 1'b0; pend_q <= '0; idx_q <= '0;
        end
        else
        begin
            st_q <= st_d; cur_q <= cur_d; val_q <= val_d; row_q <= row_d; dig_q <= dig_d;
            rowseen_q <= rowseen_d; pend_q <= pend_d; idx_q <= idx_d;
        end
    end

    // Executed commands update the settings; a restore also wipes the rows.
    cfg_t        cfg_q, cfg_d;
    logic [7:0]  baddr_q, baddr_d;
    logic        slave_q, slave_d, boot_q, boot_d;
    logic        xv_d;
    logic [4:0]  xc_d;
    logic [18:0] xval_d;
    logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [7:0]  sp_d;
    logic        ready_bit, err_bit;

    assign ready_bit = st_q[0];
    assign err_bit   = |stat_q[EV_NOT_REM:EV_BAD_CMD];

    always_comb
    begin
        cfg_d = cfg_q; baddr_d = baddr_q; slave_d = slave_q; boot_d = boot_q;
        xv_d = st_q[4]; xc_d = PRIO[idx_q]; xval_d = rdata;
        if (st_q[4])
        begin
            boot_d = 1'b0;
            unique case (PRIO[idx_q])
                L_R: cfg_d = clear_cfg('0);
                5'h00: cfg_d.trig_rise = rdata[0];
                5'h01: cfg_d.ready_pos = rdata[0];
                5'h05: cfg_d.trig_en   = rdata[0];
                5'h06: cfg_d.fmt       = rdata[2:0];
                5'h0A: cfg_d.eoi_hold  = rdata[2:0];
                5'h0C: cfg_d.srq_mask  = rdata[7:0];
                5'h0E: cfg_d.dig_out   = rdata[15:0];
                5'h12: cfg_d.settle    = rdata[15:0];
                5'h13: cfg_d.trig_src  = rdata[2:0];
                5'h18: cfg_d.term      = rdata[2:0];
                5'h04: cfg_d.edit_ptr  = rdata[6:0];
                5'h15: cfg_d.mb_rows   = rdata[7:0];
                5'h16: cfg_d.bm_rows   = rdata[7:0];
                default: cfg_d = cfg_q;
            endcase
        end
        if (boot_q && loop_init)
            slave_d = 1'b1;
        if (dev_clear)
            cfg_d = clear_cfg(cfg_q);
        if (reg_wr && reg_addr == REG_BUS)
            baddr_d = reg_wdata[7:0];
        stat_d = stat_q;
        if (reg_wr && reg_addr == REG_STATUS)
            stat_d = stat_q & ~reg_wdata[EV_W-1:0];
        // Hardware events win over a clear written in the same cycle.
        stat_d[EV_BAD_CMD] = stat_d[EV_BAD_CMD] | ev_bad_cmd;
        stat_d[EV_BAD_OPT] = stat_d[EV_BAD_OPT] | ev_bad_opt;
        stat_d[EV_NOT_REM] = stat_d[EV_NOT_REM] | ev_not_rem;
        stat_d[EV_EXEC]    = stat_d[EV_EXEC] | (st_q[4] && idx_q == PRIO_LAST)
                             | (st_q[3] && idx_q == PRIO_LAST && !pend_q[PRIO[idx_q]]);
        mask_d = (reg_wr && reg_addr == REG_MASK) ? reg_wdata[EV_W-1:0] : mask_q;
        sp_d = {1'b0, srq, err_bit, ready_bit, matrix_ready ^ ~cfg_q.ready_pos, 3'b000};
    end

    // Power-up lands stand-alone with defaults; the address is reset only here, the rows here and by a restore.
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cfg_q <= clear_cfg('0); baddr_q <= ADDR_INIT; slave_q <= 1'b0;
            boot_q <= 1'b1; exec_valid <= 1'b0; exec_cmd <= '0; exec_value <= '0;
            stat_q <= '0; mask_q <= '0; spoll_byte <= '0; spoll_ack <= 1'b0;
            slave_clear <= 1'b0; reg_rdata <= '0;
        end
        else
        begin
            cfg_q <= cfg_d; baddr_q <= baddr_d; slave_q <= slave_d; boot_q <= boot_d;
            exec_valid <= xv_d; exec_cmd <= xc_d; exec_value <= xval_d;
            stat_q <= stat_d; mask_q <= mask_d;
            spoll_ack <= spoll_req;
            if (spoll_req)
                spoll_byte <= sp_d;
            slave_clear <= dev_clear && !slave_q;
            if (reg_rd)
                unique case (reg_addr)
                    REG_STATUS: reg_rdata <= {12'h000, stat_q};
                    REG_MASK:   reg_rdata <= {12'h000, mask_q};
                    REG_MODES:  reg_rdata <= {1'b0, cfg_q.trig_rise, cfg_q.ready_pos,
                                    cfg_q.trig_en, cfg_q.fmt, cfg_q.eoi_hold,
                                    cfg_q.trig_src, cfg_q.term};
                    REG_DIGOUT: reg_rdata <= cfg_q.dig_out;
                    REG_SETTLE: reg_rdata <= cfg_q.settle;
                    REG_EDIT:   reg_rdata <= {9'h000, cfg_q.edit_ptr};
                    REG_ROWS:   reg_rdata <= {cfg_q.mb_rows, cfg_q.bm_rows};
                    REG_BUS:    reg_rdata <= {7'h00, slave_q, baddr_q};
                endcase
            else
                reg_rdata <= '0;
        end
    end

    assign irq = |(stat_q & mask_q);
    assign srq = |(cfg_q.srq_mask[5:3] & {err_bit, ready_bit, matrix_ready});

    property p_atn_ignored;
        @(posedge mclk) disable iff (!rst_sync_n)
        (rx_valid && rx_ready && atn && !dev_clear)
            |=> $stable(st_q) && $stable(val_q) && $stable(cur_q);
    endproperty
    a_atn_ignored: assert property (p_atn_ignored) else $error("byte taken under attention");
    property p_poll;
        @(posedge mclk) disable iff (!rst_sync_n)
        spoll_req |=> spoll_ack && spoll_byte[4] == $past(ready_bit);
    endproperty
    a_poll: assert property (p_poll) else $error("poll byte not returned");
    property p_no_exec_while_buffering;
        @(posedge mclk) disable iff (!rst_sync_n)
        (st_q == ST_CMD || st_q == ST_OPT) |=> !exec_valid;
    endproperty
    a_no_exec_while_buffering: assert property (p_no_exec_while_buffering) else $error("early execution");
    property p_drop_holds;
        @(posedge mclk) disable iff (!rst_sync_n)
        (st_q == ST_DROP && !(take && rx_data == CH_X) && !dev_clear) |=> st_q == ST_DROP;
    endproperty
    a_drop_holds: assert property (p_drop_holds) else $error("discard left early");
    property p_local_x;
        @(posedge mclk) disable iff (!rst_sync_n)
        ((st_q == ST_CMD || (st_q == ST_OPT && grp_ok)) && take && rx_data == CH_X
         && !remote && !dev_clear) |=> stat_q[EV_NOT_REM] && st_q == ST_CMD;
    endproperty
    a_local_x: assert property (p_local_x) else $error("local execute not flagged");
    property p_space;
        @(posedge mclk) disable iff (!rst_sync_n)
        (take && rx_data == CH_SPACE && !dev_clear) |=> $stable(st_q) && $stable(val_q);
    endproperty
    a_space: assert property (p_space) else $error("space changed parser");
    property p_order;
        @(posedge mclk) disable iff (!rst_sync_n)
        (st_q == ST_OUT && idx_q != PRIO_LAST && !dev_clear) |=> st_q == ST_RD && idx_q == $past(idx_q) + 5'h01;
    endproperty
    a_order: assert property (p_order) else $error("priority walk broken");
    property p_clear_defaults;
        @(posedge mclk) disable iff (!rst_sync_n)
        dev_clear |=> cfg_q.trig_src == TRIG_SRC_EXT && cfg_q.fmt == 3'h0 && cfg_q.eoi_hold == 3'h0
                      && baddr_q == $past(baddr_q) && slave_q == $past(slave_q);
    endproperty
    a_clear_defaults: assert property (p_clear_defaults) else $error("device clear defaults wrong");
    property p_bad_cmd;
        @(posedge mclk) disable iff (!rst_sync_n)
        (ev_bad_cmd && !dev_clear) |=> st_q == ST_DROP;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not discarded");
    c_exec: cover property (@(posedge mclk) disable iff (!rst_sync_n) exec_valid);
    c_bad_opt: cover property (@(posedge mclk) disable iff (!rst_sync_n) ev_bad_opt);
    c_poll: cover property (@(posedge mclk) disable iff (!rst_sync_n) spoll_ack && srq);
endmodule
`default_nettype wire

// ==== ddc_pkg.sv ====
// Shared constants, types and tables of the command interpreter.
package ddc_pkg;

    // Register indexes of the plain register port.
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_MASK   = 3'h1;
    localparam logic [2:0] REG_MODES  = 3'h2;
    localparam logic [2:0] REG_DIGOUT = 3'h3;
    localparam logic [2:0] REG_SETTLE = 3'h4;
    localparam logic [2:0] REG_EDIT   = 3'h5;
    localparam logic [2:0] REG_ROWS   = 3'h6;
    localparam logic [2:0] REG_BUS    = 3'h7;

    // Event bit positions of the status and mask registers.
    localparam int EV_BAD_CMD  = 0;
    localparam int EV_BAD_OPT  = 1;
    localparam int EV_NOT_REM  = 2;
    localparam int EV_EXEC     = 3;
    localparam int EV_W        = 4;

    // Characters of the command language.
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_NINE  = 8'h39;
    localparam logic [7:0] CH_A     = 8'h41;
    localparam logic [7:0] CH_H     = 8'h48;
    localparam logic [7:0] CH_X     = 8'h58;
    localparam logic [7:0] CH_Z     = 8'h5A;

    // Letter indexes, letter minus capital A.
    localparam logic [4:0] L_C = 5'h02;
    localparam logic [4:0] L_D = 5'h03;
    localparam logic [4:0] L_H = 5'h07;
    localparam logic [4:0] L_N = 5'h0D;
    localparam logic [4:0] L_R = 5'h11;
    localparam logic [4:0] L_X = 5'h17;
    localparam logic [4:0] L_Z = 5'h19;

    localparam logic [15:0] VAL_MAX    = 16'hFFFF;
    localparam logic [15:0] COL_MAX    = 16'h003C;
    localparam logic [7:0]  ADDR_INIT  = 8'h12;
    localparam logic [6:0]  MEM_STEP1  = 7'h01;
    localparam int          NPRIO      = 24;
    localparam logic [4:0]  PRIO_LAST  = 5'h17;

    // Fixed execution order after the execute character, as letter indexes.
    localparam logic [4:0] PRIO [0:NPRIO-1] = '{
        5'h11, 5'h0B, 5'h04, 5'h08, 5'h10, 5'h0F, 5'h19, 5'h15,
        5'h16, 5'h0D, 5'h02, 5'h00, 5'h01, 5'h05, 5'h06, 5'h09,
        5'h0A, 5'h0C, 5'h0E, 5'h03, 5'h12, 5'h13, 5'h14, 5'h18};

    typedef struct packed {
        logic        trig_rise;
        logic        ready_pos;
        logic        trig_en;
        logic [2:0]  fmt;
        logic [2:0]  eoi_hold;
        logic [7:0]  srq_mask;
        logic [15:0] dig_out;
        logic [15:0] settle;
        logic [2:0]  trig_src;
        logic [2:0]  term;
        logic [6:0]  edit_ptr;
        logic [7:0]  mb_rows;
        logic [7:0]  bm_rows;
    } cfg_t;

    localparam logic [2:0] TRIG_SRC_EXT = 3'h7;

    // Defaults after power-up and device clear; the row selections survive.
    function automatic cfg_t clear_cfg(input cfg_t cur);
        cfg_t c;
        c          = '0;
        c.trig_src = TRIG_SRC_EXT;
        c.mb_rows  = cur.mb_rows;
        c.bm_rows  = cur.bm_rows;
        return c;
    endfunction

    // Largest option value per command letter; zero means the option must be 0.
    function automatic logic [15:0] opt_max(input logic [4:0] l);
        logic [15:0] m;
        m = VAL_MAX;
        unique case (l)
            5'h00, 5'h01, 5'h05: m = 16'h0001;
            5'h06, 5'h13:        m = 16'h0007;
            5'h0A:               m = 16'h0005;
            5'h09, 5'h11:        m = 16'h0000;
            5'h04, 5'h08, 5'h0F, 5'h10: m = 16'h0064;
            5'h18:               m = 16'h0007;
            5'h0C, 5'h15, 5'h16: m = 16'h00FF;
            default:             m = VAL_MAX;
        endcase
        return m;
    endfunction

    function automatic logic is_cmd(input logic [4:0] l);
        return (l != L_H) && (l != L_X) && (l <= L_Z);
    endfunction

endpackage

// ==== ddc_reset_sync.sv ====
// Reset release synchroniser for the instrument clock.
`timescale 1ns/100ps
`default_nettype none
module ddc_reset_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      rst_sync_n
);
    logic meta_q;
    logic hold_q;

    // Assertion is immediate, release waits two clock edges.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end

    assign rst_sync_n = hold_q;
endmodule
`default_nettype wire

// ==== ddc_cmd_store.sv ====
// Per-letter option store: one word for each command letter.
`timescale 1ns/100ps
`default_nettype none
module ddc_cmd_store #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 19,
    parameter int AW    = 5
) (
    input  wire logic             mclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    // Writing a letter again overwrites, so only its last occurrence survives.
    always_ff @(posedge mclk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ==== ddc_ctl_model.sv ====
// Bus controller model that offers command bytes to the parser.
`timescale 1ns/100ps
`default_nettype none
module ddc_ctl_model (
    input  wire logic  mclk,
    input  wire logic  rx_ready,
    output logic [7:0] rx_data = 8'h00,
    output logic       rx_valid = 1'b0,
    output logic       atn = 1'b0
);
    // A byte is held until an edge that sees the parser ready.
    task automatic put(input logic [7:0] b, input logic a);
        rx_data <= b;
        rx_valid <= 1'b1;
        atn <= a;
        do @(negedge mclk); while (rx_ready !== 1'b1);
        @(posedge mclk);
    endtask
    // Released data shows its inverse so a stale byte cannot pass for a new one.
    task automatic done;
        rx_valid <= 1'b0;
        atn <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge mclk);
    endtask
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++)
            put(s[i], 1'b0);
        done;
    endtask
endmodule
`default_nettype wire

// ==== ddc_command_parser_test.sv ====
// Self-checking bench of the command interpreter.
`timescale 1ns/100ps
`default_nettype none
module ddc_command_parser_test;
    import ddc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  rx_data, spoll_byte;
    logic        rx_valid, rx_ready, atn, spoll_ack, srq, slave_clear, exec_valid, irq;
    logic        remote = 1'b1;
    logic        dev_clear = 1'b0;
    logic        loop_init = 1'b0;
    logic        spoll_req = 1'b0;
    logic [4:0]  exec_cmd;
    logic [18:0] exec_value;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        rd_q = 1'b0;
    logic        sp_q = 1'b0;
    logic [23:0] eq[$];
    logic [15:0] rq[$];
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          seed = 32'h1d84_47fd;
    logic [2:0]  v;

    ddc_command_parser u_ddc_command_parser (.mclk, .rst_n, .rx_data, .rx_valid,
        .rx_ready, .atn, .remote, .dev_clear, .loop_init, .matrix_ready(1'b0),
        .spoll_req, .spoll_byte, .spoll_ack, .srq, .slave_clear, .exec_valid,
        .exec_cmd, .exec_value, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    ddc_ctl_model u_ddc_ctl_model (.mclk, .rx_ready, .rx_data, .rx_valid, .atn);

    initial
    begin
        forever #25 mclk = ~mclk;
    end

    task automatic end_sim;
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic idle;
        repeat (40) @(posedge mclk);
    endtask

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        rd_q <= reg_rd;
        sp_q <= spoll_req;
        if (exec_valid === 1'b1)
            chk({exec_cmd, exec_value}, eq.size() > 0 ? eq.pop_front() : 24'hff_ffff);
        if (rd_q === 1'b1)
            chk({8'h00, reg_rdata}, {8'h00, rq.pop_front()});
        if (sp_q === 1'b1)
        begin
            chk({23'h00_0000, spoll_ack}, 24'h00_0001);
            chk({21'h00_0000, spoll_byte[6:4]}, 24'h00_0001);
        end
        if (cyc == 5000)
        begin
            error_cnt++;
            end_sim;
        end
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(REG_MODES, 16'h0038);
        rd(REG_BUS, 16'h0012);
        eq.push_back({5'h13, 19'h0_0004});
        u_ddc_ctl_model.send("T0T2T4X");
        idle;
        rd(REG_STATUS, 16'h0008);
        wr(REG_STATUS, 16'h000f);
        eq.push_back({5'h00, 19'h0_0001});
        eq.push_back({5'h13, 19'h0_0006});
        u_ddc_ctl_model.send("T6 A1X");
        idle;
        wr(REG_STATUS, 16'h000f);
        u_ddc_ctl_model.send("A0K7X");
        u_ddc_ctl_model.send("CA1A2X");
        u_ddc_ctl_model.send("T1hX");
        idle;
        rd(REG_STATUS, 16'h0003);
        u_ddc_ctl_model.send("T1");
        u_ddc_ctl_model.put("T", 1'b1);
        u_ddc_ctl_model.put("5", 1'b1);
        u_ddc_ctl_model.done;
        idle;
        rd(REG_MODES, 16'h4030);
        eq.push_back({5'h13, 19'h0_0001});
        u_ddc_ctl_model.send("X");
        idle;
        wr(REG_STATUS, 16'h000f);
        remote <= 1'b0;
        u_ddc_ctl_model.send("T2X");
        idle;
        rd(REG_STATUS, 16'h0004);
        remote <= 1'b1;
        wr(REG_MASK, 16'h0004);
        @(posedge mclk);
        chk({23'h00_0000, irq}, 24'h00_0001);
        wr(REG_STATUS, 16'h000f);
        @(posedge mclk);
        chk({23'h00_0000, irq}, 24'h00_0000);
        wr(REG_BUS, 16'h0005);
        loop_init <= 1'b1;
        @(posedge mclk);
        loop_init <= 1'b0;
        dev_clear <= 1'b1;
        @(posedge mclk);
        dev_clear <= 1'b0;
        #1 chk({23'h00_0000, slave_clear}, 24'h00_0001);
        idle;
        rd(REG_MODES, 16'h0038);
        rd(REG_BUS, 16'h0005);
        repeat (4)
        begin
            v = 3'($random(seed));
            eq.push_back({5'h13, 16'h0000, v});
            u_ddc_ctl_model.put("T", 1'b0);
            u_ddc_ctl_model.put(8'h30 + {5'h00, v}, 1'b0);
            u_ddc_ctl_model.put("X", 1'b0);
            u_ddc_ctl_model.done;
            idle;
        end
        spoll_req <= 1'b1;
        @(posedge mclk);
        spoll_req <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({23'h00_0000, eq.size() == 0}, 24'h00_0001);
        end_sim;
    end
endmodule
`default_nettype wire
